// file: common/isr_pkg.sv
// constants for the impedance status and result register group
// assumes a byte-wide register port driven by the serial interface logic
// Operation
// - status register read-only at 8fh
// - set temperature done on valid result
// - clear temperature done on command, power-up
// - set point done when results stored
// - clear point done on start/step/repeat/reset
// - sweep done set at end, cleared
// - leakage done set, cleared on command/reset
// - leakage pass bits d4 to d6
// - leakage pass bits survive reset
// - d7 mirrors master fuse state
// - fuse blown blocks otp programming
// - 9-bit sweep index at 90h/91h
// - index zeroed at start, steps, capped
// - index cleared at power-up, not reset
// - 14-bit temperature result at 92h/93h
// - 32 counts per degree scaling
// - temperature result kept through resets
// - real at 94h, imaginary at 96h
// - transform results kept through resets
// - command from control high nibble
// - reset command keeps programmed registers
package isr_pkg;
    localparam logic [7:0] ADDR_STATUS   = 8'h8f;
    localparam logic [7:0] ADDR_CTRL_HI  = 8'h80;
    localparam logic [7:0] ADDR_INDEX_HI = 8'h90;
    localparam logic [7:0] ADDR_INDEX_LO = 8'h91;
    localparam logic [7:0] ADDR_TEMP_HI  = 8'h92;
    localparam logic [7:0] ADDR_TEMP_LO  = 8'h93;
    localparam logic [7:0] ADDR_REAL_HI  = 8'h94;
    localparam logic [7:0] ADDR_REAL_LO  = 8'h95;
    localparam logic [7:0] ADDR_IMAG_HI  = 8'h96;
    localparam logic [7:0] ADDR_IMAG_LO  = 8'h97;
    localparam int BIT_TEMP_DONE  = 0;
    localparam int BIT_POINT_DONE = 1;
    localparam int BIT_SWEEP_DONE = 2;
    localparam int BIT_LEAK_DONE  = 3;
    localparam int BIT_LEAK_LO    = 4;
    localparam int BIT_FUSE       = 7;
    localparam int INDEX_W        = 9;
    localparam int TEMP_W         = 14;
    localparam int TEMP_COUNTS_PER_DEG = 32;
    localparam int TEMP_NEG_OFFSET     = 16384;
    localparam int RESULT_W       = 16;
    localparam logic [INDEX_W-1:0] INDEX_RESET = 9'h000;
    // command codes in control bits d15..d12
    localparam logic [3:0] CMD_NOP       = 4'h0;
    localparam logic [3:0] CMD_INIT      = 4'h1;
    localparam logic [3:0] CMD_START     = 4'h2;
    localparam logic [3:0] CMD_STEP      = 4'h3;
    localparam logic [3:0] CMD_REPEAT    = 4'h4;
    localparam logic [3:0] CMD_FUSE_MODE = 4'h8;
    localparam logic [3:0] CMD_TEMP      = 4'h9;
    localparam logic [3:0] CMD_LEAK      = 4'hc;
    localparam int CTRL_RESET_BIT = 4;
endpackage

// file: logic/isr_cmd_decode.sv
// command decoder for writes to the control register high and low bytes
// assumes one-cycle write strobes on the system clock
`timescale 1ns/1ps
module isr_cmd_decode (
    input  wire logic       wr_en_i,
    input  wire logic [7:0] wr_addr_i,
    input  wire logic [7:0] wr_data_i,
    output logic            cmd_start_o,
    output logic            cmd_step_o,
    output logic            cmd_repeat_o,
    output logic            cmd_temp_o,
    output logic            cmd_leak_o,
    output logic            cmd_reset_o
);
    logic hi_wr;
    logic lo_wr;
    logic [3:0] code;
    assign hi_wr = wr_en_i && (wr_addr_i == isr_pkg::ADDR_CTRL_HI);
    assign lo_wr = wr_en_i && (wr_addr_i == (isr_pkg::ADDR_CTRL_HI + 8'h01));
    assign code  = wr_data_i[7:4];
    // top nibble of the high byte carries the command
    assign cmd_start_o  = hi_wr && (code == isr_pkg::CMD_START);
    assign cmd_step_o   = hi_wr && (code == isr_pkg::CMD_STEP);
    assign cmd_repeat_o = hi_wr && (code == isr_pkg::CMD_REPEAT);
    assign cmd_temp_o   = hi_wr && (code == isr_pkg::CMD_TEMP);
    assign cmd_leak_o   = hi_wr && (code == isr_pkg::CMD_LEAK);
    // reset bit d4 sits in the low byte
    assign cmd_reset_o  = lo_wr && wr_data_i[isr_pkg::CTRL_RESET_BIT];
endmodule

// file: logic/isr_status_regs.sv
// status and result registers of the impedance measurement core
// assumes datapath event strobes on ref_clk_i; fuse level comes from the otp array
`timescale 1ns/1ps
module isr_status_regs (
    input  wire logic        ref_clk_i,
    input  wire logic        nrst_i,
    input  wire logic        wr_en_i,
    input  wire logic [7:0]  wr_addr_i,
    input  wire logic [7:0]  wr_data_i,
    input  wire logic [7:0]  rd_addr_i,
    output logic [7:0]       rd_data_o,
    input  wire logic [8:0]  num_incr_i,
    input  wire logic        temp_done_i,
    input  wire logic [13:0] temp_code_i,
    input  wire logic        point_done_i,
    input  wire logic [15:0] real_i,
    input  wire logic [15:0] imag_i,
    input  wire logic        leak_done_i,
    input  wire logic [2:0]  leak_pass_i,
    input  wire logic        fuse_blown_i,
    input  wire logic        otp_prog_req_i,
    output logic             otp_prog_en_o,
    output logic             cmd_start_o,
    output logic             cmd_step_o,
    output logic             cmd_repeat_o,
    output logic             cmd_temp_o,
    output logic             cmd_leak_o,
    output logic             cmd_reset_o
);
    // ******************************
    // command decode
    // ******************************
    logic c_start;
    logic c_step;
    logic c_repeat;
    logic c_temp;
    logic c_leak;
    logic c_reset;

    isr_cmd_decode u_dec (
        .wr_en_i      (wr_en_i),
        .wr_addr_i    (wr_addr_i),
        .wr_data_i    (wr_data_i),
        .cmd_start_o  (c_start),
        .cmd_step_o   (c_step),
        .cmd_repeat_o (c_repeat),
        .cmd_temp_o   (c_temp),
        .cmd_leak_o   (c_leak),
        .cmd_reset_o  (c_reset)
    );

    assign cmd_start_o  = c_start;
    assign cmd_step_o   = c_step;
    assign cmd_repeat_o = c_repeat;
    assign cmd_temp_o   = c_temp;
    assign cmd_leak_o   = c_leak;
    assign cmd_reset_o  = c_reset;

    // ******************************
    // fuse synchroniser and otp gate
    // ******************************
    logic fuse_meta;
    logic fuse_sync;

    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            fuse_meta <= 1'b0;
            fuse_sync <= 1'b0;
        end else begin
            fuse_meta <= fuse_blown_i;
            fuse_sync <= fuse_meta;
        end
    end

    // blown fuse stops any otp write once it is through the two-stage synchroniser
    assign otp_prog_en_o = otp_prog_req_i && !fuse_sync;

    // ******************************
    // status flags
    // ******************************
    logic       temp_done;
    logic       point_done;
    logic       sweep_done;
    logic       leak_done;
    logic [2:0] leak_pass;
    logic       last_point;
    // declared here since the sweep-end compare reads it before the index section
    logic [8:0] index_cnt;

    assign last_point = (index_cnt >= num_incr_i);

    // set wins over a clear in the same cycle
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            temp_done <= 1'b0;
        end else if (temp_done_i) begin
            temp_done <= 1'b1;
        end else if (c_temp) begin
            temp_done <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            point_done <= 1'b0;
        end else if (point_done_i) begin
            point_done <= 1'b1;
        end else if (c_start || c_step || c_repeat || c_reset) begin
            point_done <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            sweep_done <= 1'b0;
        end else if (point_done_i && last_point) begin
            sweep_done <= 1'b1;
        end else if (c_reset || c_start) begin
            sweep_done <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            leak_done <= 1'b0;
        end else if (leak_done_i) begin
            leak_done <= 1'b1;
        end else if (c_leak || c_reset) begin
            leak_done <= 1'b0;
        end
    end

    // no reset term: pass bits survive power-up and reset commands
    always_ff @(posedge ref_clk_i) begin
        if (leak_done_i) begin
            leak_pass <= leak_pass_i;
        end
    end

    // ******************************
    // sweep index
    // ******************************
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            index_cnt <= isr_pkg::INDEX_RESET;
        end else if (c_start) begin
            index_cnt <= isr_pkg::INDEX_RESET;
        end else if (c_step && (index_cnt < num_incr_i)) begin
            index_cnt <= index_cnt + 9'h001;
        end
    end

    // ******************************
    // result words
    // ******************************
    // whole words load in one edge, but a load between the high and low byte reads still splits a result
    logic [13:0] temp_word;
    logic [15:0] real_word;
    logic [15:0] imag_word;

    // code is 32 counts per degree, sign at d13
    always_ff @(posedge ref_clk_i) begin
        if (temp_done_i) begin
            temp_word <= temp_code_i;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (point_done_i) begin
            real_word <= real_i;
            imag_word <= imag_i;
        end
    end

    // ******************************
    // read mux
    // ******************************
    logic [7:0] status_byte;
    logic [7:0] next_rd_data;

    // d7 follows the synchronised fuse level
    assign status_byte = {fuse_sync, leak_pass, leak_done, sweep_done, point_done, temp_done};

    // writes never reach these registers
    always_comb begin
        next_rd_data = 8'h00;
        unique case (rd_addr_i)
            isr_pkg::ADDR_STATUS:   next_rd_data = status_byte;
            isr_pkg::ADDR_INDEX_HI: next_rd_data = {7'h00, index_cnt[8]};
            isr_pkg::ADDR_INDEX_LO: next_rd_data = index_cnt[7:0];
            isr_pkg::ADDR_TEMP_HI:  next_rd_data = {2'h0, temp_word[13:8]};
            isr_pkg::ADDR_TEMP_LO:  next_rd_data = temp_word[7:0];
            isr_pkg::ADDR_REAL_HI:  next_rd_data = real_word[15:8];
            isr_pkg::ADDR_REAL_LO:  next_rd_data = real_word[7:0];
            isr_pkg::ADDR_IMAG_HI:  next_rd_data = imag_word[15:8];
            isr_pkg::ADDR_IMAG_LO:  next_rd_data = imag_word[7:0];
            default:                next_rd_data = 8'h00;
        endcase
    end

    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rd_data_o <= 8'h00;
        end else begin
            rd_data_o <= next_rd_data;
        end
    end
endmodule

// file: sim/isr_host_model.sv
// host side of the byte register port
// assumes callers enter its tasks on a falling clock edge
`timescale 1ns/1ps
module isr_host_model (
    input  wire logic       ref_clk_i,
    input  wire logic [7:0] rd_data_i,
    output logic            wr_en_o,
    output logic [7:0]      wr_addr_o,
    output logic [7:0]      wr_data_o,
    output logic [7:0]      rd_addr_o
);
    // *****
    // register cycles
    // *****
    initial begin
        wr_en_o = 1'h0;
        wr_addr_o = 8'h00;
        wr_data_o = 8'h00;
        rd_addr_o = 8'h8f;
    end
    // commands go to the control high byte, reset bit to the low byte
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        wr_en_o = 1'h1;
        wr_addr_o = a;
        wr_data_o = d;
        @(negedge ref_clk_i);
        wr_en_o = 1'h0;
        wr_data_o = ~d;
        @(negedge ref_clk_i);
    endtask
    // read data is registered, so it lands one edge later
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        rd_addr_o = a;
        @(negedge ref_clk_i);
        d = rd_data_i;
    endtask
endmodule

// file: sim/isr_status_properties.sv
// checker for the status and result register group
// assumes a bind onto isr_status_regs, one clock domain
`timescale 1ns/1ps
module isr_status_properties (
    input wire logic        ref_clk_i,
    input wire logic        nrst_i,
    input wire logic        wr_en_i,
    input wire logic [7:0]  wr_addr_i,
    input wire logic [7:0]  wr_data_i,
    input wire logic [7:0]  rd_addr_i,
    input wire logic [7:0]  rd_data_o,
    input wire logic        temp_done_i,
    input wire logic        point_done_i,
    input wire logic [15:0] real_i,
    input wire logic        fuse_blown_i,
    input wire logic        otp_prog_en_o,
    input wire logic        cmd_start_o,
    input wire logic        cmd_step_o,
    input wire logic        cmd_repeat_o,
    input wire logic        cmd_temp_o,
    input wire logic        cmd_leak_o,
    input wire logic        cmd_reset_o
);
    // *****
    // properties
    // *****
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!nrst_i);
    AST_TEMP_SET: assert property ((temp_done_i ##1 rd_addr_i == 8'h8f) |=> rd_data_o[0])
        else $error("temp flag not set");
    AST_TEMP_CLR: assert property ((cmd_temp_o && !temp_done_i ##1 rd_addr_i == 8'h8f) |=> !rd_data_o[0])
        else $error("temp flag not cleared");
    AST_POINT_SET: assert property ((point_done_i ##1 rd_addr_i == 8'h8f) |=> rd_data_o[1])
        else $error("point flag not set");
    AST_CMD_TEMP: assert property (wr_en_i && wr_addr_i == 8'h80 && wr_data_i[7:4] == 4'h9 |-> cmd_temp_o)
        else $error("temp command lost");
    AST_CMD_RESET: assert property (wr_en_i && wr_addr_i == 8'h81 && wr_data_i[4] |-> cmd_reset_o)
        else $error("reset command lost");
    AST_CMD_START: assert property (wr_en_i && wr_addr_i == 8'h80 && wr_data_i[7:4] == 4'h2 |-> cmd_start_o)
        else $error("start command lost");
    AST_CMD_STEP: assert property (wr_en_i && wr_addr_i == 8'h80 && wr_data_i[7:4] == 4'h3 |-> cmd_step_o)
        else $error("step command lost");
    AST_CMD_REPEAT: assert property (wr_en_i && wr_addr_i == 8'h80 && wr_data_i[7:4] == 4'h4 |-> cmd_repeat_o)
        else $error("repeat command lost");
    AST_CMD_LEAK: assert property (wr_en_i && wr_addr_i == 8'h80 && wr_data_i[7:4] == 4'hc |-> cmd_leak_o)
        else $error("leakage command lost");
    AST_REAL_LOAD: assert property ((point_done_i ##1 rd_addr_i == 8'h94) |=>
        {rd_data_o, 8'h00} == ($past(real_i, 2) & 16'hff00))
        else $error("real high byte wrong");
    AST_UNMAPPED: assert property (rd_addr_i == 8'h00 |=> rd_data_o == 8'h00)
        else $error("unmapped read not zero");
    AST_FUSE_BLOCK: assert property (fuse_blown_i [*3] |-> !otp_prog_en_o)
        else $error("programming not blocked");
    AST_FUSE_FLAG: assert property ((fuse_blown_i [*3] ##1 rd_addr_i == 8'h8f) |=> rd_data_o[7])
        else $error("fuse flag low");
endmodule
bind isr_status_regs isr_status_properties u_chk (.ref_clk_i, .nrst_i, .wr_en_i, .wr_addr_i, .wr_data_i,
    .rd_addr_i, .rd_data_o, .temp_done_i, .point_done_i, .real_i, .fuse_blown_i, .otp_prog_en_o,
    .cmd_start_o, .cmd_step_o, .cmd_repeat_o, .cmd_temp_o, .cmd_leak_o, .cmd_reset_o);

// file: sim/isr_status_regs_tb.sv
// self-checking bench for the status and result register group
// assumes the host model and the bound checker compiled first
`timescale 1ns/1ps
module isr_status_regs_tb;
    logic        ref_clk_i, nrst_i, wr_en_i, temp_done_i, point_done_i, leak_done_i, fuse_blown_i;
    logic        otp_prog_req_i, otp_prog_en_o, cmd_start_o, cmd_step_o, cmd_repeat_o, cmd_temp_o, cmd_leak_o;
    logic        cmd_reset_o;
    logic [7:0]  wr_addr_i, wr_data_i, rd_addr_i, rd_data_o, d;
    logic [8:0]  num_incr_i;
    logic [13:0] temp_code_i;
    logic [15:0] real_i, imag_i;
    logic [2:0]  leak_pass_i;
    int          num_errors = 0;
    int          n_compared = 0;
    isr_status_regs DUT (.*);
    isr_host_model host (.ref_clk_i, .rd_data_i(rd_data_o), .wr_en_o(wr_en_i), .wr_addr_o(wr_addr_i),
        .wr_data_o(wr_data_i), .rd_addr_o(rd_addr_i));
    // *****
    // helpers and scenarios
    // *****
    initial begin
        ref_clk_i = 1'h0;
        forever #12.5 ref_clk_i = ~ref_clk_i;
    end
    task automatic end_sim();
        if (num_errors == 0 && n_compared > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        n_compared++;
        if (g !== e) begin
            num_errors++;
            $display("MISMATCH %s exp %h got %h", n, e, g);
        end
    endtask
    // masks hide bits that are not yet loaded
    task automatic cmp(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
        host.rd(a, d);
        chk($sformatf("reg %h", a), e, d & m);
    endtask
    task automatic pulse(ref logic s);
        s = 1'h1;
        @(negedge ref_clk_i);
        s = 1'h0;
    endtask
    // flags are set before each checked clear so every checked clear has something to undo
    task automatic s_temp();
        pulse(temp_done_i);
        cmp(8'h8f, 8'h01, 8'h01);
        host.wr(8'h8f, 8'h00);
        cmp(8'h8f, 8'h01, 8'h01);
        host.wr(8'h80, 8'h90);
        cmp(8'h8f, 8'h01, 8'h00);
        pulse(temp_done_i);
        cmp(8'h92, 8'hff, 8'h3f);
        cmp(8'h93, 8'hff, 8'hf5);
        cmp(8'h00, 8'hff, 8'h00);
    endtask
    task automatic s_sweep();
        host.wr(8'h80, 8'h20);
        cmp(8'h91, 8'hff, 8'h00);
        pulse(point_done_i);
        cmp(8'h8f, 8'h06, 8'h02);
        host.wr(8'h80, 8'h30);
        cmp(8'h8f, 8'h02, 8'h00);
        pulse(point_done_i);
        cmp(8'h94, 8'hff, 8'h8a);
        cmp(8'h96, 8'hff, 8'h7f);
        cmp(8'h97, 8'hff, 8'hff);
        cmp(8'h90, 8'hff, 8'h00);
        cmp(8'h91, 8'hff, 8'h01);
        host.wr(8'h80, 8'h40);
        cmp(8'h8f, 8'h02, 8'h00);
        host.wr(8'h80, 8'h30);
        pulse(point_done_i);
        cmp(8'h8f, 8'h06, 8'h06);
        host.wr(8'h80, 8'h30);
        cmp(8'h91, 8'hff, 8'h02);
        pulse(point_done_i);
        host.wr(8'h81, 8'h10);
        cmp(8'h8f, 8'h06, 8'h00);
        cmp(8'h91, 8'hff, 8'h02);
        host.wr(8'h80, 8'h20);
        cmp(8'h91, 8'hff, 8'h00);
        host.wr(8'h80, 8'h30);
        host.wr(8'h80, 8'h30);
    endtask
    task automatic s_leak_fuse();
        pulse(leak_done_i);
        cmp(8'h8f, 8'h78, 8'h38);
        host.wr(8'h80, 8'hc0);
        cmp(8'h8f, 8'h78, 8'h30);
        pulse(leak_done_i);
        host.wr(8'h81, 8'h10);
        cmp(8'h8f, 8'h78, 8'h30);
        otp_prog_req_i = 1'h1;
        @(negedge ref_clk_i);
        chk("otp_prog_en_o", 8'h01, {7'h00, otp_prog_en_o});
        fuse_blown_i = 1'h1;
        repeat (3) @(negedge ref_clk_i);
        chk("otp_prog_en_o", 8'h00, {7'h00, otp_prog_en_o});
        cmp(8'h8f, 8'h80, 8'h80);
        // every flag is up before power-up reset, so the clear check below bites
        pulse(point_done_i);
        pulse(leak_done_i);
        nrst_i = 1'h0;
        @(negedge ref_clk_i);
        nrst_i = 1'h1;
        cmp(8'h91, 8'hff, 8'h00);
        cmp(8'h8f, 8'h0f, 8'h00);
        cmp(8'h8f, 8'hf0, 8'hb0);
        cmp(8'h95, 8'hff, 8'h51);
        cmp(8'h93, 8'hff, 8'hf5);
    endtask
    // a hang is cut short well inside the run budget
    initial begin
        repeat (20000) @(posedge ref_clk_i);
        num_errors++;
        end_sim();
    end
    initial begin
        nrst_i = 1'h0;
        {temp_done_i, point_done_i, leak_done_i, fuse_blown_i, otp_prog_req_i} = 5'h00;
        num_incr_i = 9'h002;
        temp_code_i = 14'h3ff5;
        real_i = 16'h8a51;
        imag_i = 16'h7fff;
        leak_pass_i = 3'h3; // asymmetric so a swapped pass bit shows
        repeat (10) @(negedge ref_clk_i);
        nrst_i = 1'h1;
        s_temp();
        s_sweep();
        s_leak_fuse();
        end_sim();
    end
endmodule
